// ### hdl/kds_pkg.sv
package kds_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int FULL_SCAN_US = 2750;
    localparam int SCAN_POINTS = 64;
    localparam int POINT_CYC = (FULL_SCAN_US * 1000) / SCAN_POINTS / CLK_PERIOD_NS;
    localparam int DCLK_PERIOD_US = 100;
    localparam int DCLK_HALF_CYC = (DCLK_PERIOD_US * 1000) / 2 / CLK_PERIOD_NS;
    localparam logic [1:0] DEBOUNCE_SCANS = 2'h3;

    // Keyboard modes
    localparam logic [1:0] KBD_ENCODED = 2'h0;
    localparam logic [1:0] KBD_SCANNED = 2'h1;
    localparam logic [1:0] KBD_SENSOR = 2'h2;

    // Display modes
    localparam logic [2:0] DISP_SCAN16 = 3'h0;
    localparam logic [2:0] DISP_SCAN8 = 3'h1;
    localparam logic [2:0] DISP_GD16 = 3'h2;
    localparam logic [2:0] DISP_GD18 = 3'h3;
    localparam logic [2:0] DISP_GD20 = 3'h4;

    // Gas discharge frame figures
    localparam logic [7:0] FRAME_SHORT = 8'h6F;
    localparam logic [7:0] FRAME_LONG = 8'h8B;
    localparam logic [2:0] CHAR_LEN_7 = 3'h7;
    localparam logic [2:0] CHAR_LEN_6 = 3'h6;
    localparam logic [2:0] CHAR_VALID = 3'h5;
    localparam logic [7:0] GD18_BLANK_FIRST = 8'h6C;
    localparam logic [7:0] GD18_BLANK_LAST = 8'h6E;
    localparam logic [4:0] CHARS_16 = 5'h10;
    localparam logic [4:0] CHARS_18 = 5'h12;
    localparam logic [4:0] CHARS_20 = 5'h14;

    // Blank code and FIFO status
    localparam logic [3:0] BLANK_A = 4'h2;
    localparam logic [3:0] BLANK_B = 4'h0;
    localparam logic [3:0] STATUS_OVERRUN = 4'hF;
    localparam logic [3:0] FIFO_DEPTH = 4'h8;

    typedef enum logic [1:0] {KDS_IDLE, KDS_DEBOUNCE, KDS_HELD} kds_key_e;
endpackage

// ### hdl/kds_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module kds_sync3 #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Pins and filtered result
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] clean_out
);
    // Three stages per bit; a change is taken once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    clean_out[i] <= 1'b0;
                end else begin
                    s1_reg <= pins_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        clean_out[i] <= s3_reg;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### hdl/kds_scanner.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01: Least significant digit of both banks shows during strobe zero, next digits follow.
// RULE_02: Sixteen-digit mode: bank select low for first eight digits, high for next eight.
// RULE_03: Eight-digit mode shows least significant digit at every strobe-zero time.
// RULE_04: Gas discharge display clock has about 100 us period, 50% duty.
// RULE_05: Reset pulse one clock long every 111th period, or 139th for 20 characters.
// RULE_06: Character period is seven clocks, or six clocks for 18 characters.
// RULE_07: Character data valid only during first five clocks of each character period.
// RULE_08: Character 0 starts at rising edge of the reset pulse.
// RULE_09: Reset on bank A bit 3, clock on bit 2; blank is A1 high, rest low.
// RULE_10: In 18 character mode, periods 108 to 110 output blank.
// RULE_11: Chip-select command blanks or unblanks all display outputs. In gas discharge modes the A3 reset and A2 clock bits keep running.
// RULE_12: Sensor mode samples all eight returns per strobe into 64 memory bits.
// RULE_13: Sensor mode disables debounce, rollover, shift and control inputs.
// RULE_14: Sensor mode interrupt stays high while any sensor bit is set.
// RULE_15: Scan strobes are a single active bit rotating from 0 to 7.
// RULE_16: Several keys in one scan: keep scanning until only one remains.
// RULE_17: Single key latches its code and starts four further scans.
// RULE_18: Accept key only if still pressed alone in fourth scan, with shift/control.
// RULE_19: Full FIFO drops accepted key and sets overrun; else enqueue and interrupt.
// RULE_20: Second key released first is ignored; held past first becomes new depression.
// RULE_21: Key code is scan index high three bits, return index low three.
// RULE_22: Encoded mode writes the eight return levels into the FIFO as one character.
// RULE_23: FIFO status shows count 0 to 8, or 15 after overrun.
// RULE_24: Return index cycles through all eight lines per scan index advance.
// RULE_25: Scan rate divided from clock so a full scan lasts about 2.75 ms.
module kds_scanner (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Configuration
    input wire logic [1:0] kbd_mode_in,
    input wire logic [2:0] disp_mode_in,
    // Commands
    input wire logic chip_select_command_in,
    input wire logic chip_select_blank_in,
    input wire logic display_mode_command_in,
    input wire logic fifo_clear_in,
    // Display memory write port
    input wire logic disp_wr_in,
    input wire logic disp_wr_bank_b_in,
    input wire logic [4:0] disp_wr_addr_in,
    input wire logic [3:0] disp_wr_data_in,
    // FIFO and sensor read port
    input wire logic fifo_pop_in,
    input wire logic [2:0] sensor_group_in,
    output logic [7:0] fifo_data_out,
    output logic [3:0] fifo_status_out,
    output logic [7:0] sensor_row_out,
    output logic int_out,
    // Matrix pins
    input wire logic [7:0] return_sense_lines_in,
    input wire logic shift_key_in,
    input wire logic control_key_in,
    output logic [7:0] scan_strobes_out,
    output logic digit_bank_select_out,
    // Display pins
    output logic [3:0] display_bank_a_out,
    output logic [3:0] display_bank_b_out
);
    logic [9:0] pins_clean;
    logic [7:0] ret;
    logic shift_key;
    logic ctl_key;

    kds_sync3 #(.WIDTH(10)) u_sync (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .pins_in({control_key_in, shift_key_in, return_sense_lines_in}),
        .clean_out(pins_clean)
    );
    assign ret = pins_clean[7:0];
    assign shift_key = pins_clean[8];
    assign ctl_key = pins_clean[9];

    // Scan point divider
    logic [9:0] pt_cnt_reg;
    logic pt_tick;
    assign pt_tick = (pt_cnt_reg == 10'(kds_pkg::POINT_CYC - 1));
    always_ff @(posedge mclk_in) begin
        if (reset_in || pt_tick) begin
            pt_cnt_reg <= 10'h000;
        end else begin
            pt_cnt_reg <= pt_cnt_reg + 10'h001; // RULE_25
        end
    end

    // Scan and return counters, strobe ring, bank select flip-flop
    logic [2:0] s_idx_reg;
    logic [2:0] r_idx_reg;
    logic bank_sel_reg;
    logic scan_end;
    assign scan_end = pt_tick && (s_idx_reg == 3'h7) && (r_idx_reg == 3'h7);
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            s_idx_reg <= 3'h0;
            r_idx_reg <= 3'h0;
            scan_strobes_out <= 8'h01;
            bank_sel_reg <= 1'b0;
        end else if (pt_tick) begin
            r_idx_reg <= r_idx_reg + 3'h1; // RULE_24
            if (r_idx_reg == 3'h7) begin
                s_idx_reg <= s_idx_reg + 3'h1;
                scan_strobes_out <= {scan_strobes_out[6:0], scan_strobes_out[7]}; // RULE_15
                if (s_idx_reg == 3'h7) begin
                    bank_sel_reg <= ~bank_sel_reg; // RULE_02
                end
            end
        end
    end
    assign digit_bank_select_out = bank_sel_reg;

    // Sensor memory: a whole return row per strobe; bits only cleared by reset or the clear command
    logic [7:0] sensor_mem [0:7];
    logic sensor_any;
    always_ff @(posedge mclk_in) begin
        if (reset_in || fifo_clear_in) begin
            for (int k = 0; k < 8; k++) begin
                sensor_mem[k] <= 8'h00;
            end
        end
        // A sample that meets a clear survives it; the later assignment wins
        if (!reset_in && kbd_mode_in == kds_pkg::KBD_SENSOR && pt_tick && r_idx_reg == 3'h7) begin
            sensor_mem[s_idx_reg] <= (fifo_clear_in ? 8'h00 : sensor_mem[s_idx_reg]) | ret; // RULE_12 RULE_13
        end
    end
    always_comb begin
        sensor_any = 1'b0;
        for (int k = 0; k < 8; k++) begin
            sensor_any = sensor_any | (|sensor_mem[k]);
        end
    end

    // Per-scan key tally; keys other than the tracked one are counted
    kds_pkg::kds_key_e st_reg;
    logic [5:0] code_now;
    logic [5:0] tgt_reg;
    logic [5:0] oth_code_reg;
    logic [1:0] n_oth_reg;
    logic tgt_seen_reg;
    logic [1:0] deb_cnt_reg;
    logic hit;
    logic is_tgt;
    logic [1:0] n_oth_upd;
    logic [5:0] oth_code_upd;
    logic tgt_seen_upd;
    assign code_now = {s_idx_reg, r_idx_reg}; // RULE_21
    assign hit = pt_tick && (kbd_mode_in == kds_pkg::KBD_SCANNED) && ret[r_idx_reg];
    assign is_tgt = (st_reg != kds_pkg::KDS_IDLE) && (code_now == tgt_reg);
    always_comb begin
        n_oth_upd = n_oth_reg;
        oth_code_upd = oth_code_reg;
        tgt_seen_upd = tgt_seen_reg;
        if (hit && is_tgt) begin
            tgt_seen_upd = 1'b1;
        end else if (hit) begin
            n_oth_upd = (n_oth_reg == 2'h0) ? 2'h1 : 2'h2;
            if (n_oth_reg == 2'h0) begin
                oth_code_upd = code_now;
            end
        end
    end
    always_ff @(posedge mclk_in) begin
        if (reset_in || scan_end) begin
            n_oth_reg <= 2'h0;
            oth_code_reg <= 6'h00;
            tgt_seen_reg <= 1'b0;
        end else begin
            n_oth_reg <= n_oth_upd;
            oth_code_reg <= oth_code_upd;
            tgt_seen_reg <= tgt_seen_upd;
        end
    end

    // Debounce and two-key rollover, judged at each scan end
    logic enq_key;
    assign enq_key = scan_end && (st_reg == kds_pkg::KDS_DEBOUNCE) && (deb_cnt_reg == kds_pkg::DEBOUNCE_SCANS)
        && tgt_seen_upd && (n_oth_upd == 2'h0); // RULE_18
    always_ff @(posedge mclk_in) begin
        if (reset_in || kbd_mode_in != kds_pkg::KBD_SCANNED) begin
            st_reg <= kds_pkg::KDS_IDLE; // RULE_13
            tgt_reg <= 6'h00;
            deb_cnt_reg <= 2'h0;
        end else if (scan_end) begin
            case (st_reg)
                kds_pkg::KDS_IDLE: begin
                    // Two or more keys: stay and look again next scan
                    if (n_oth_upd == 2'h1) begin // RULE_16
                        tgt_reg <= oth_code_upd; // RULE_17
                        deb_cnt_reg <= 2'h0;
                        st_reg <= kds_pkg::KDS_DEBOUNCE;
                    end
                end
                kds_pkg::KDS_DEBOUNCE: begin
                    deb_cnt_reg <= deb_cnt_reg + 2'h1; // RULE_17
                    if (deb_cnt_reg == kds_pkg::DEBOUNCE_SCANS) begin
                        st_reg <= enq_key ? kds_pkg::KDS_HELD : kds_pkg::KDS_IDLE; // RULE_18
                    end
                end
                kds_pkg::KDS_HELD: begin
                    // A second key that outlasts the first becomes a fresh depression
                    if (!tgt_seen_upd) begin
                        if (n_oth_upd == 2'h1) begin // RULE_20
                            tgt_reg <= oth_code_upd;
                            deb_cnt_reg <= 2'h0;
                            st_reg <= kds_pkg::KDS_DEBOUNCE;
                        end else begin
                            st_reg <= kds_pkg::KDS_IDLE;
                        end
                    end
                end
                default: begin
                    st_reg <= kds_pkg::KDS_IDLE;
                end
            endcase
        end
    end

    // Encoded keyboard: a new nonzero return pattern is one character
    logic [7:0] ret_prev_reg;
    logic enq_enc;
    assign enq_enc = (kbd_mode_in == kds_pkg::KBD_ENCODED) && (ret != ret_prev_reg) && (ret != 8'h00);
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ret_prev_reg <= 8'h00;
        end else begin
            ret_prev_reg <= ret;
        end
    end

    // Character FIFO; overrun sticks until cleared while reads go on
    logic [7:0] fifo_mem [0:7];
    logic [2:0] wr_ptr_reg;
    logic [2:0] rd_ptr_reg;
    logic [3:0] count_reg;
    logic overrun_reg;
    logic enq;
    logic do_wr;
    logic do_rd;
    logic [7:0] enq_data;
    assign enq = enq_key || enq_enc;
    assign enq_data = enq_enc ? ret : {ctl_key, shift_key, tgt_reg}; // RULE_18 RULE_22
    assign do_wr = enq && (count_reg != kds_pkg::FIFO_DEPTH); // RULE_19
    assign do_rd = fifo_pop_in && (count_reg != 4'h0) && (kbd_mode_in != kds_pkg::KBD_SENSOR);
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            wr_ptr_reg <= 3'h0;
            rd_ptr_reg <= 3'h0;
            count_reg <= 4'h0;
            overrun_reg <= 1'b0;
        end else if (fifo_clear_in) begin
            // A character arriving with the clear is kept in the emptied queue
            wr_ptr_reg <= {2'h0, enq};
            rd_ptr_reg <= 3'h0;
            count_reg <= {3'h0, enq};
            overrun_reg <= 1'b0;
        end else begin
            if (enq && !do_wr) begin
                overrun_reg <= 1'b1; // RULE_19
            end
            if (do_wr) begin
                wr_ptr_reg <= wr_ptr_reg + 3'h1;
            end
            if (do_rd) begin
                rd_ptr_reg <= rd_ptr_reg + 3'h1;
            end
            count_reg <= count_reg + {3'h0, do_wr} - {3'h0, do_rd};
        end
    end
    always_ff @(posedge mclk_in) begin
        if (fifo_clear_in && enq) begin
            fifo_mem[0] <= enq_data;
        end else if (do_wr) begin
            fifo_mem[wr_ptr_reg] <= enq_data;
        end
    end

    // Read-side outputs from flip-flops
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            fifo_data_out <= 8'h00;
            fifo_status_out <= 4'h0;
            sensor_row_out <= 8'h00;
            int_out <= 1'b0;
        end else begin
            fifo_data_out <= (count_reg != 4'h0) ? fifo_mem[rd_ptr_reg] : 8'h00;
            fifo_status_out <= overrun_reg ? kds_pkg::STATUS_OVERRUN : count_reg; // RULE_23
            sensor_row_out <= sensor_mem[sensor_group_in];
            if (kbd_mode_in == kds_pkg::KBD_SENSOR) begin
                int_out <= sensor_any; // RULE_14
            end else begin
                int_out <= (count_reg != 4'h0) || overrun_reg; // RULE_19
            end
        end
    end

    // Display memory; the mode command forces every slot to the blank code
    logic [3:0] disp_a_mem [0:19];
    logic [3:0] disp_b_mem [0:19];
    always_ff @(posedge mclk_in) begin
        if (reset_in || display_mode_command_in) begin
            for (int k = 0; k < 20; k++) begin
                disp_a_mem[k] <= kds_pkg::BLANK_A;
                disp_b_mem[k] <= kds_pkg::BLANK_B;
            end
        end else if (disp_wr_in && disp_wr_addr_in < kds_pkg::CHARS_20) begin
            if (disp_wr_bank_b_in) begin
                disp_b_mem[disp_wr_addr_in] <= disp_wr_data_in;
            end else begin
                disp_a_mem[disp_wr_addr_in] <= disp_wr_data_in;
            end
        end
    end

    // Blanking by chip-select command
    logic blank_reg;
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            blank_reg <= 1'b0;
        end else if (chip_select_command_in) begin
            blank_reg <= chip_select_blank_in; // RULE_11
        end
    end

    // Gas discharge timing: display clock, period, phase and character
    logic gd_mode;
    logic gd18;
    logic [7:0] frame_len;
    logic [2:0] char_len;
    logic [4:0] n_chars;
    logic [9:0] dclk_cnt_reg;
    logic dclk_reg;
    logic dclk_rise;
    logic [7:0] per_reg;
    logic [2:0] phase_reg;
    logic [4:0] char_reg;
    assign gd_mode = (disp_mode_in == kds_pkg::DISP_GD16) || gd18 || (disp_mode_in == kds_pkg::DISP_GD20);
    assign gd18 = (disp_mode_in == kds_pkg::DISP_GD18);
    assign frame_len = (disp_mode_in == kds_pkg::DISP_GD20) ? kds_pkg::FRAME_LONG : kds_pkg::FRAME_SHORT; // RULE_05
    assign char_len = gd18 ? kds_pkg::CHAR_LEN_6 : kds_pkg::CHAR_LEN_7; // RULE_06
    assign n_chars = gd18 ? kds_pkg::CHARS_18
        : ((disp_mode_in == kds_pkg::DISP_GD20) ? kds_pkg::CHARS_20 : kds_pkg::CHARS_16);
    assign dclk_rise = (dclk_cnt_reg == 10'(kds_pkg::DCLK_HALF_CYC - 1)) && !dclk_reg;
    always_ff @(posedge mclk_in) begin
        if (reset_in || !gd_mode) begin
            dclk_cnt_reg <= 10'h000;
            dclk_reg <= 1'b0;
        end else if (dclk_cnt_reg == 10'(kds_pkg::DCLK_HALF_CYC - 1)) begin
            dclk_cnt_reg <= 10'h000;
            dclk_reg <= ~dclk_reg; // RULE_04
        end else begin
            dclk_cnt_reg <= dclk_cnt_reg + 10'h001;
        end
    end
    // Period 0 carries the reset pulse and opens character 0
    always_ff @(posedge mclk_in) begin
        if (reset_in || !gd_mode) begin
            per_reg <= 8'h00;
            phase_reg <= 3'h0;
            char_reg <= 5'h00;
        end else if (dclk_rise) begin
            if (per_reg >= frame_len - 8'h01) begin
                per_reg <= 8'h00; // RULE_05
                phase_reg <= 3'h0; // RULE_08
                char_reg <= 5'h00;
            end else begin
                per_reg <= per_reg + 8'h01;
                if (phase_reg >= char_len - 3'h1) begin
                    phase_reg <= 3'h0; // RULE_06
                    char_reg <= char_reg + 5'h01;
                end else begin
                    phase_reg <= phase_reg + 3'h1;
                end
            end
        end
    end

    // Display pins: digit follows the strobe in scanned modes
    logic [4:0] scan_digit;
    logic gd_blank;
    assign scan_digit = (disp_mode_in == kds_pkg::DISP_SCAN8) ? {2'h0, s_idx_reg} // RULE_03
        : {1'b0, bank_sel_reg, s_idx_reg}; // RULE_01 RULE_02
    assign gd_blank = blank_reg || (phase_reg >= kds_pkg::CHAR_VALID) || (char_reg >= n_chars) // RULE_07
        || (gd18 && per_reg >= kds_pkg::GD18_BLANK_FIRST && per_reg <= kds_pkg::GD18_BLANK_LAST); // RULE_10
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            display_bank_a_out <= 4'h0;
            display_bank_b_out <= 4'h0;
        end else if (gd_mode) begin
            display_bank_a_out[3] <= (per_reg == 8'h00); // RULE_09
            display_bank_a_out[2] <= dclk_reg; // RULE_09
            display_bank_a_out[1:0] <= gd_blank ? kds_pkg::BLANK_A[1:0] : disp_a_mem[char_reg][1:0];
            display_bank_b_out <= gd_blank ? kds_pkg::BLANK_B : disp_b_mem[char_reg];
        end else begin
            display_bank_a_out <= blank_reg ? kds_pkg::BLANK_A : disp_a_mem[scan_digit]; // RULE_11
            display_bank_b_out <= blank_reg ? kds_pkg::BLANK_B : disp_b_mem[scan_digit];
        end
    end

    // Checks
    strobe_onehot_a: assert property (@(posedge mclk_in) disable iff (reset_in) $onehot(scan_strobes_out)) // RULE_15
        else $error("scan strobes not one-hot");
    strobe_step_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (pt_tick && r_idx_reg == 3'h7) |=> scan_strobes_out == {$past(scan_strobes_out[6:0]), $past(scan_strobes_out[7])}) // RULE_24
        else $error("strobe did not advance after eight returns");
    bank_toggle_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        scan_end |=> digit_bank_select_out != $past(digit_bank_select_out)) // RULE_02
        else $error("bank select did not toggle at scan end");
    overrun_set_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (enq && count_reg == 4'h8 && !fifo_clear_in) |=> ##1 fifo_status_out == 4'hF) // RULE_19
        else $error("overrun not reported");
    sensor_int_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (kbd_mode_in == kds_pkg::KBD_SENSOR && sensor_any) |=> int_out) // RULE_14
        else $error("sensor interrupt low with bits set");
    key_accept_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (enq_key && count_reg == 4'h0 && !overrun_reg && !fifo_clear_in)
        |=> ##1 (fifo_data_out[5:0] == $past(tgt_reg, 2) && fifo_status_out == 4'h1)) // RULE_18
        else $error("accepted key not queued");
    gd_reset_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (gd_mode && per_reg == 8'h00) |=> display_bank_a_out[3]) // RULE_05
        else $error("reset pulse missing in period zero");
    gd_late_blank_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (gd_mode && phase_reg >= 3'h5) |=> display_bank_a_out[1:0] == 2'h2 && display_bank_b_out == 4'h0) // RULE_07
        else $error("character data outside valid clocks");
    gd18_tail_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        (gd18 && per_reg >= kds_pkg::GD18_BLANK_FIRST && per_reg <= kds_pkg::GD18_BLANK_LAST)
        |=> display_bank_b_out == 4'h0) // RULE_10
        else $error("18 character tail not blank");
endmodule
`default_nettype wire

// ### sim/kds_matrix_model.sv
`timescale 1ns/1ps
`default_nettype none
module kds_matrix_model (
    // Scan side
    input wire logic [7:0] scan_strobes_in,
    input wire logic encoded_en_in,
    input wire logic [7:0] enc_byte_in,
    input wire logic [63:0] closed_keys_in,
    // Return side
    output logic [7:0] return_sense_lines_out
);
    // Closed switch ties its strobe to its return; open lines sit at the pull-down level
    always_comb begin
        return_sense_lines_out = 8'h00;
        for (int s = 0; s < 8; s++) begin
            if (scan_strobes_in[s]) begin
                return_sense_lines_out |= closed_keys_in[s*8 +: 8];
            end
        end
        if (encoded_en_in) begin
            return_sense_lines_out = enc_byte_in;
        end
    end
endmodule
`default_nettype wire

// ### sim/keyboard_display_scanner_bench.sv
`timescale 1ns/1ps
`default_nettype none
module keyboard_display_scanner_bench;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [1:0] kbd_mode = kds_pkg::KBD_ENCODED;
    logic [2:0] disp_mode = kds_pkg::DISP_SCAN16;
    logic cs_cmd = 1'b0, cs_blank = 1'b0, wr = 1'b0, wr_b = 1'b0, pop = 1'b0, clr = 1'b0, enc_en = 1'b1;
    logic [4:0] wr_addr = 5'h00;
    logic [3:0] wr_data = 4'h0;
    logic [2:0] group = 3'h0;
    logic [7:0] enc_byte = 8'h00;
    logic [63:0] keys = 64'h0;
    logic [7:0] fifo_data, sensor_row, strobes, ret;
    logic [3:0] status, bank_a, bank_b;
    logic irq, bank_sel;
    int n_mismatch = 0, n_checks = 0, cyc = 0;

    // 20 MHz clock
    always #25 mclk_in = ~mclk_in;

    // Keyboard modifiers tied: a scanned-key debounce runs too long to reach here
    kds_scanner i_kds_scanner (.mclk_in(mclk_in), .reset_in(reset_in), .kbd_mode_in(kbd_mode),
        .disp_mode_in(disp_mode), .chip_select_command_in(cs_cmd), .chip_select_blank_in(cs_blank),
        .display_mode_command_in(1'b0), .fifo_clear_in(clr), .disp_wr_in(wr), .disp_wr_bank_b_in(wr_b),
        .disp_wr_addr_in(wr_addr), .disp_wr_data_in(wr_data), .fifo_pop_in(pop), .sensor_group_in(group),
        .fifo_data_out(fifo_data), .fifo_status_out(status), .sensor_row_out(sensor_row), .int_out(irq),
        .return_sense_lines_in(ret), .shift_key_in(1'b0), .control_key_in(1'b0), .scan_strobes_out(strobes),
        .digit_bank_select_out(bank_sel), .display_bank_a_out(bank_a), .display_bank_b_out(bank_b));

    kds_matrix_model i_kds_matrix_model (.scan_strobes_in(strobes), .encoded_en_in(enc_en),
        .enc_byte_in(enc_byte), .closed_keys_in(keys), .return_sense_lines_out(ret));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Every return to the bench lands on a falling edge, so drives never race the design
    task automatic ticks(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // Nine bytes into an eight-deep queue: the last one must overrun
    task automatic t_encoded;
        for (int i = 0; i < 9; i++) begin
            enc_byte = enc_byte + 8'h11;
            ticks(12);
            if (i == 7) chk("fifo count", 8'h08, {4'h0, status});
        end
        chk("fifo status", {4'h0, kds_pkg::STATUS_OVERRUN}, {4'h0, status});
        chk("fifo head", 8'h11, fifo_data);
        chk("interrupt", 8'h01, {7'h0, irq});
        pop = 1'b1;
        ticks(1);
        pop = 1'b0;
        ticks(4);
        chk("fifo next", 8'h22, fifo_data);
        chk("overrun sticky", 8'h0F, {4'h0, status});
        enc_byte = 8'h00;
        ticks(8);
        clr = 1'b1;
        ticks(1);
        clr = 1'b0;
        ticks(4);
        chk("cleared status", 8'h00, {4'h0, status});
        chk("cleared interrupt", 8'h00, {7'h0, irq});
        enc_en = 1'b0;
        kbd_mode = kds_pkg::KBD_SENSOR;
    endtask

    // Load digits 0..7, then blank and unblank while strobe zero is still live
    task automatic t_display;
        for (int d = 0; d < 8; d++) begin
            wr_addr = 5'(d);
            wr = 1'b1;
            wr_b = 1'b0;
            wr_data = 4'(d + 3);
            ticks(1);
            wr_b = 1'b1;
            wr_data = 4'(12 - d);
            ticks(1);
        end
        wr = 1'b0;
        cs_blank = 1'b1;
        cs_cmd = 1'b1;
        ticks(1);
        cs_cmd = 1'b0;
        ticks(4);
        chk("blanked a", {4'h0, kds_pkg::BLANK_A}, {4'h0, bank_a});
        chk("blanked b", {4'h0, kds_pkg::BLANK_B}, {4'h0, bank_b});
        cs_blank = 1'b0;
        cs_cmd = 1'b1;
        ticks(1);
        cs_cmd = 1'b0;
        ticks(4);
        chk("unblanked a", 8'h03, {4'h0, bank_a});
    endtask

    // One full scan plus the wrap, with two closures on strobe two in sensor mode
    task automatic t_scan;
        int w;
        for (int k = 0; k < 9; k++) begin
            w = 0;
            while (strobes !== 8'h01 << (k % 8) && w < 8000) begin
                ticks(1);
                w++;
            end
            if (k == 2) keys = 64'h0000_0000_0022_0000;
            ticks(2000);
            chk("strobe", 8'h01 << (k % 8), strobes);
            chk("bank select", {7'h0, k == 8}, {7'h0, bank_sel});
            chk("digit a", k < 8 ? 8'(k + 3) : {4'h0, kds_pkg::BLANK_A}, {4'h0, bank_a});
            chk("digit b", k < 8 ? 8'(12 - k) : {4'h0, kds_pkg::BLANK_B}, {4'h0, bank_b});
            if (k == 3) begin
                keys = 64'h0;
                group = 3'h2;
                ticks(2);
                chk("sensor row", 8'h22, sensor_row);
                chk("sensor interrupt", 8'h01, {7'h0, irq});
                group = 3'h0;
                ticks(2);
                chk("idle row", 8'h00, sensor_row);
            end
            if (k == 5) begin
                clr = 1'b1;
                ticks(1);
                clr = 1'b0;
                ticks(4);
                chk("sensor interrupt off", 8'h00, {7'h0, irq});
            end
        end
    endtask

    // Eight-digit mode on bank one, then gas discharge reset period and clock halves
    task automatic t_modes;
        disp_mode = kds_pkg::DISP_SCAN8;
        ticks(2);
        chk("scan8 digit a", 8'h03, {4'h0, bank_a});
        disp_mode = kds_pkg::DISP_GD16;
        ticks(500);
        chk("gd reset a", 8'h0B, {4'h0, bank_a});
        chk("gd char b", 8'h0C, {4'h0, bank_b});
        ticks(1000);
        chk("gd clock high a", 8'h07, {4'h0, bank_a});
        ticks(1000);
        chk("gd clock low a", 8'h03, {4'h0, bank_a});
    endtask

    // Main sequence
    initial begin
        ticks(8);
        reset_in = 1'b0;
        ticks(1);
        chk("reset strobes", 8'h01, strobes);
        chk("reset status", 8'h00, {4'h0, status});
        t_encoded;
        t_display;
        t_scan;
        t_modes;
        end_sim;
    end

    // A full scan is about 55k cycles; the ceiling leaves margin for the rest
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            end_sim;
        end
    end
endmodule
`default_nettype wire
